// [verilog/sadc_pkg.sv]
// Purpose: Shared constants and types for the SAR converter control block
// Assumes: One 25 MHz clock, synchronous active-high reset
// Notes on behaviour
// - Start high clears the approximation register.
// - Conversion begins when start falls.
// - Start during conversion restarts the sequence.
// - Done low while converting, high after.
// - Channel address captured on latch rising edge.
// - Address bit zero is least significant.
// - Result bit zero is least significant.
// - Expansion low disconnects all internal channels; the sample-hold variant ignores it.
// - Output control high drives, low floats.
// - Sample-hold variant: start latches address, samples.
// - Conversion end loads result into latch.
// - Each trial selects a divider tap.
// - Sixteen channels large, eight otherwise.
`default_nettype none
package sadc_pkg;
	localparam int unsigned ADDR_W      = 32'd8;
	localparam int unsigned RES_W       = 8;
	localparam int unsigned CHAN_BIG    = 16;
	localparam int unsigned CHAN_SMALL  = 8;
	localparam logic [11:0] OFF_CTRL    = 12'h000;
	localparam logic [11:0] OFF_STATUS  = 12'h004;
	localparam logic [11:0] OFF_RESULT  = 12'h008;
	localparam logic [11:0] OFF_IRQ_ST  = 12'h00c;
	localparam logic [11:0] OFF_IRQ_MSK = 12'h010;
	localparam int unsigned CTRL_START  = 0;
	localparam int unsigned CTRL_ALE    = 1;
	localparam int unsigned CTRL_OE     = 2;
	localparam int unsigned CTRL_EXPN   = 3;
	localparam int unsigned CTRL_ADDR   = 4;
	localparam logic [31:0] CTRL_RESET  = 32'h0000_0008;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		SADC_IDLE,
		SADC_HOLD,
		SADC_TRIAL,
		SADC_LOAD
	} sadc_state_t;
	// Field order mirrors the control word: address on top, start at bit zero
	typedef struct packed {
		logic [3:0] addr;
		logic       expn_n;
		logic       oe;
		logic       ale;
		logic       start;
	} sadc_ctrl_t;
endpackage
`default_nettype wire

// [verilog/sadc_sar.sv]
// Purpose: Successive approximation sequencer with result latch
// Assumes: Comparator answer valid in the cycle its tap is shown
// Notes: Start is level sensitive and acts as the register reset
`default_nettype none
module sadc_sar
	import sadc_pkg::*;
#(
	parameter int unsigned WIDTH = RES_W
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst,
	input  wire logic             i_start,
	input  wire logic             i_cmp_le,
	output logic      [WIDTH-1:0] o_tap,
	output logic      [WIDTH-1:0] o_result,
	output logic                  o_done,
	output logic                  o_sample,
	output logic                  o_eoc_pulse
);
	sadc_state_t      state_q;
	logic [WIDTH-1:0] sar_q;
	logic [WIDTH-1:0] bit_q;
	logic             start_q;
	logic [WIDTH-1:0] kept_w;

	// Keep bit only if tap does not exceed input
	assign kept_w = i_cmp_le ? sar_q : (sar_q & ~bit_q);

	always_ff @(posedge i_clock) begin
		if (i_rst)
			start_q <= 1'b0;
		else
			start_q <= i_start;
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state_q     <= SADC_IDLE;
			sar_q       <= '0;
			bit_q       <= '0;
			o_result    <= '0;
			o_done      <= 1'b0;
			o_eoc_pulse <= 1'b0;
		end else begin
			o_eoc_pulse <= 1'b0;
			if (i_start) begin
				state_q <= SADC_HOLD;
				sar_q   <= '0;
				bit_q   <= '0;
				o_done  <= 1'b0;
			end else begin
				case (state_q)
					SADC_IDLE: begin
					end
					SADC_HOLD: begin
						if (start_q) begin
							state_q <= SADC_TRIAL;
							bit_q   <= {1'b1, {(WIDTH-1){1'b0}}};
							sar_q   <= {1'b1, {(WIDTH-1){1'b0}}};
						end
					end
					SADC_TRIAL: begin
						if (bit_q[0]) begin
							sar_q   <= kept_w;
							state_q <= SADC_LOAD;
						end else begin
							sar_q <= kept_w | (bit_q >> 1);
							bit_q <= bit_q >> 1;
						end
					end
					SADC_LOAD: begin
						o_result    <= sar_q;
						o_done      <= 1'b1;
						o_eoc_pulse <= 1'b1;
						state_q     <= SADC_IDLE;
					end
					default: state_q <= SADC_IDLE;
				endcase
			end
		end
	end

	assign o_tap    = sar_q;
	assign o_sample = i_start;

	a_done_after_load: assert property (@(posedge i_clock) disable iff (i_rst)
		state_q == SADC_LOAD && !i_start |=> o_done && o_result == $past(sar_q))
		else $error("done or result not updated at load");
	a_start_clears: assert property (@(posedge i_clock) disable iff (i_rst)
		i_start |=> sar_q == '0 && !o_done)
		else $error("start did not clear register");
	a_trial_length: assert property (@(posedge i_clock) disable iff (i_rst)
		state_q == SADC_HOLD && start_q && !i_start ##1 !i_start [*8] ##1 !i_start |=> o_done)
		else $error("conversion did not finish in eight trials");
	a_done_low_busy: assert property (@(posedge i_clock) disable iff (i_rst)
		state_q == SADC_TRIAL |-> !o_done)
		else $error("done high during conversion");
	c_full_conv: cover property (@(posedge i_clock) $rose(o_done));
	c_restart: cover property (@(posedge i_clock) state_q == SADC_TRIAL && i_start);
endmodule
`default_nettype wire

// [verilog/sadc_top.sv]
// Purpose: AXI4-Lite controlled SAR converter with channel multiplexer
// Assumes: Comparator result arrives as a synchronous input
// Notes: Start, latch enable and output control are register bits
//
// Implementation choices: the AXI4-Lite register port and the register addresses.
`default_nettype none
module sadc_top
	import sadc_pkg::*;
#(
	parameter bit SAMPLE_HOLD = 1'b0,
	parameter bit BIG_MUX     = 1'b1
) (
	input  wire logic              i_clock,
	input  wire logic              i_rst,
	input  wire logic [ADDR_W-1:0] i_awaddr,
	input  wire logic              i_awvalid,
	output logic                   o_awready,
	input  wire logic [31:0]       i_wdata,
	input  wire logic [3:0]        i_wstrb,
	input  wire logic              i_wvalid,
	output logic                   o_wready,
	output logic [1:0]             o_bresp,
	output logic                   o_bvalid,
	input  wire logic              i_bready,
	input  wire logic [ADDR_W-1:0] i_araddr,
	input  wire logic              i_arvalid,
	output logic                   o_arready,
	output logic [31:0]            o_rdata,
	output logic [1:0]             o_rresp,
	output logic                   o_rvalid,
	input  wire logic              i_rready,
	input  wire logic              i_cmp_le,
	output logic [RES_W-1:0]       o_tap,
	output logic [CHAN_BIG-1:0]    o_chan_sel,
	output logic                   o_sample,
	output logic [RES_W-1:0]       o_result_out,
	output logic [RES_W-1:0]       o_result_oe,
	output logic                   o_done,
	output logic                   o_irq
);
	sadc_ctrl_t       ctrl_q;
	logic [3:0]       chan_q;
	logic             ale_q;
	logic [1:0]       irq_st_q;
	logic [1:0]       irq_msk_q;
	logic [ADDR_W-1:0] aw_q;
	logic [31:0]      w_q;
	logic             aw_have_q;
	logic             w_have_q;
	logic [RES_W-1:0] tap_w;
	logic [RES_W-1:0] result_w;
	logic             done_w;
	logic             sample_w;
	logic             eoc_w;
	logic             done_q;
	logic             wr_go;
	logic             latch_edge;
	logic [3:0]       chan_d;
	logic [1:0]       irq_clr;

	function automatic logic [11:0] word_off(input logic [ADDR_W-1:0] a);
		return {{(12-ADDR_W){1'b0}}, a[ADDR_W-1:2], 2'b00};
	endfunction

	sadc_sar #(
		.WIDTH(RES_W)
	) u_sar (
		.i_clock    (i_clock),
		.i_rst      (i_rst),
		.i_start    (ctrl_q.start),
		.i_cmp_le   (i_cmp_le),
		.o_tap      (tap_w),
		.o_result   (result_w),
		.o_done     (done_w),
		.o_sample   (sample_w),
		.o_eoc_pulse(eoc_w)
	);

	// Write channel: address and data accepted in either order
	assign wr_go = aw_have_q && w_have_q && !o_bvalid;

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_q      <= '0;
			w_q       <= '0;
			o_awready <= 1'b0;
			o_wready  <= 1'b0;
			o_bvalid  <= 1'b0;
			o_bresp   <= RESP_OKAY;
		end else begin
			o_awready <= !aw_have_q && !(o_awready && i_awvalid);
			o_wready  <= !w_have_q && !(o_wready && i_wvalid);
			if (o_awready && i_awvalid) begin
				aw_have_q <= 1'b1;
				aw_q      <= i_awaddr;
			end
			if (o_wready && i_wvalid) begin
				w_have_q <= 1'b1;
				w_q      <= i_wdata & {{8{i_wstrb[3]}}, {8{i_wstrb[2]}}, {8{i_wstrb[1]}}, {8{i_wstrb[0]}}};
			end
			if (wr_go) begin
				aw_have_q <= 1'b0;
				w_have_q  <= 1'b0;
				o_bvalid  <= 1'b1;
				case (word_off(aw_q))
					OFF_CTRL, OFF_IRQ_ST, OFF_IRQ_MSK: o_bresp <= RESP_OKAY;
					default:                           o_bresp <= RESP_SLVERR;
				endcase
			end else if (o_bvalid && i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end

	// Strobes are partial-write masked to zero; control keeps whole word semantics
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			ctrl_q    <= sadc_ctrl_t'(CTRL_RESET[7:0]);
			irq_msk_q <= 2'h0;
		end else if (wr_go) begin
			if (word_off(aw_q) == OFF_CTRL) begin
				ctrl_q.start  <= w_q[CTRL_START];
				ctrl_q.ale    <= w_q[CTRL_ALE];
				ctrl_q.oe     <= w_q[CTRL_OE];
				ctrl_q.expn_n <= w_q[CTRL_EXPN];
				ctrl_q.addr   <= w_q[CTRL_ADDR +: 4];
			end
			if (word_off(aw_q) == OFF_IRQ_MSK)
				irq_msk_q <= w_q[1:0];
		end
	end

	// Sample-hold part uses start as latch enable
	assign latch_edge = SAMPLE_HOLD ? (ctrl_q.start && !ale_q) : (ctrl_q.ale && !ale_q);
	assign chan_d = BIG_MUX ? ctrl_q.addr : {1'b0, ctrl_q.addr[2:0]};

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			ale_q  <= 1'b0;
			chan_q <= 4'h0;
		end else begin
			ale_q <= SAMPLE_HOLD ? ctrl_q.start : ctrl_q.ale;
			if (latch_edge)
				chan_q <= chan_d;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst)
			o_chan_sel <= '0;
		else if (!SAMPLE_HOLD && !ctrl_q.expn_n)
			o_chan_sel <= '0;
		else
			o_chan_sel <= CHAN_BIG'(1) << chan_q;
	end

	// Tap comes straight from the trial register so the comparator answers the current trial
	assign o_tap = tap_w;

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_result_out <= '0;
			o_result_oe  <= '0;
			o_sample     <= 1'b0;
			o_done       <= 1'b0;
			done_q       <= 1'b0;
		end else begin
			o_result_out <= result_w;
			o_result_oe  <= {RES_W{ctrl_q.oe}};
			o_sample     <= SAMPLE_HOLD && sample_w;
			o_done       <= done_w;
			done_q       <= done_w;
		end
	end

	// Bit 0 conversion done, bit 1 reserved; set wins over clear
	assign irq_clr = (wr_go && word_off(aw_q) == OFF_IRQ_ST) ? w_q[1:0] : 2'h0;

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			irq_st_q <= 2'h0;
			o_irq    <= 1'b0;
		end else begin
			irq_st_q <= (irq_st_q & ~irq_clr) | {1'b0, eoc_w};
			o_irq    <= |(irq_st_q & irq_msk_q);
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b0;
			o_rdata   <= '0;
			o_rresp   <= RESP_OKAY;
		end else begin
			o_arready <= !o_rvalid && !(o_arready && i_arvalid);
			if (o_arready && i_arvalid) begin
				o_rvalid <= 1'b1;
				o_rresp  <= RESP_OKAY;
				case (word_off(i_araddr))
					OFF_CTRL:    o_rdata <= {24'h0, ctrl_q};
					OFF_STATUS:  o_rdata <= {23'h0, done_q, 4'h0, chan_q};
					OFF_RESULT:  o_rdata <= {24'h0, result_w};
					OFF_IRQ_ST:  o_rdata <= {30'h0, irq_st_q};
					OFF_IRQ_MSK: o_rdata <= {30'h0, irq_msk_q};
					default: begin
						o_rdata <= '0;
						o_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (o_rvalid && i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end

	a_chan_latched: assert property (@(posedge i_clock) disable iff (i_rst)
		latch_edge |=> chan_q == $past(chan_d))
		else $error("channel not captured on latch edge");
	a_expn_off: assert property (@(posedge i_clock) disable iff (i_rst)
		!SAMPLE_HOLD && !ctrl_q.expn_n |=> o_chan_sel == '0)
		else $error("channels connected while expansion active");
	a_oe_follows: assert property (@(posedge i_clock) disable iff (i_rst)
		$changed(ctrl_q.oe) |=> o_result_oe == {RES_W{$past(ctrl_q.oe)}})
		else $error("output enable does not follow control");
	a_done_mirror: assert property (@(posedge i_clock) disable iff (i_rst)
		ctrl_q.start ##1 1'b1 |=> !o_done)
		else $error("done high after start");
	a_irq_level: assert property (@(posedge i_clock) disable iff (i_rst)
		(irq_st_q & irq_msk_q) != 2'h0 |=> o_irq)
		else $error("interrupt not raised");
	c_write: cover property (@(posedge i_clock) o_bvalid && i_bready);
	c_read: cover property (@(posedge i_clock) o_rvalid && i_rready);
	c_irq: cover property (@(posedge i_clock) $rose(o_irq));
endmodule
`default_nettype wire

// [testbench/sadc_cmp_model.sv]
// Purpose: Comparator and tap model at the converter's analog side
// Assumes: The selected channel carries i_vin
// Notes: With no channel connected the comparator input floats; the model answers with tap bit zero
`default_nettype none
module sadc_cmp_model (
	input  wire logic [7:0]  i_tap,
	input  wire logic [7:0]  i_vin,
	input  wire logic [15:0] i_chan_sel,
	output logic             o_cmp_le
);
	timeunit 1ns;
	timeprecision 1ps;
	assign o_cmp_le = (i_chan_sel != 16'h0) ? (i_tap <= i_vin) : i_tap[0];
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// Purpose: Self-checking bench for the SAR converter control block
// Assumes: Default variant, sixteen channels
// Notes: Expected results come from a bench model of the search
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import sadc_pkg::*;
	logic        i_clock = 1'b0;
	logic        i_rst = 1'b1;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [7:0]  vin = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, cmp_le, done, irq, smp;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic [7:0]  tap, res, res_oe;
	logic [15:0] chan;
	int          mismatches = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          seed;

	initial begin
		forever #20 i_clock = ~i_clock;
	end

	sadc_top dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready),
		.o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
		.i_cmp_le(cmp_le), .o_tap(tap), .o_chan_sel(chan), .o_sample(smp), .o_result_out(res),
		.o_result_oe(res_oe), .o_done(done), .o_irq(irq));

	sadc_cmp_model cmp_u (.i_tap(tap), .i_vin(vin), .i_chan_sel(chan), .o_cmp_le(cmp_le));

	task automatic close_out;
		if (mismatches == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge i_clock) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			close_out;
		end
	end

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge i_clock);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge i_clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge i_clock);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk("rdata", e, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask

	task automatic ctl(input logic s, input logic l, input logic o, input logic e, input logic [3:0] a);
		wr(OFF_CTRL[7:0], {24'h0, a, e, o, l, s});
	endtask

	function automatic logic [7:0] sar(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 7; i >= 0; i--) begin
			if ((r | (8'h01 << i)) <= v) r = r | (8'h01 << i);
		end
		return r;
	endfunction

	// Restart swaps the input so a stale search would show
	task automatic conv(input logic [7:0] v, input logic rs);
		int n;
		vin <= v;
		ctl(1'b1, 1'b0, 1'b1, 1'b1, 4'h0);
		repeat (2) @(posedge i_clock);
		chk("done_start", 32'h0, {31'h0, done});
		ctl(1'b0, 1'b0, 1'b1, 1'b1, 4'h0);
		chk("done_busy", 32'h0, {31'h0, done});
		if (rs) begin
			v = ~v;
			vin <= v;
			ctl(1'b1, 1'b0, 1'b1, 1'b1, 4'h0);
			ctl(1'b0, 1'b0, 1'b1, 1'b1, 4'h0);
		end
		n = 0;
		while (done !== 1'b1 && n < 40) begin
			@(posedge i_clock);
			n++;
		end
		chk("done_end", 32'h1, {31'h0, done});
		chk("result", {24'h0, sar(v)}, {24'h0, res});
		chk("sample", 32'h0, {31'h0, smp});
		rchk(OFF_RESULT[7:0], {24'h0, sar(v)}, RESP_OKAY);
		chk("result_oe", 32'hff, {24'h0, res_oe});
	endtask

	initial begin
		seed = $urandom(32'hc88d9ca2);
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		@(posedge i_clock);
		rchk(OFF_CTRL[7:0], CTRL_RESET, RESP_OKAY);
		for (int a = 0; a < 16; a++) begin
			ctl(1'b0, 1'b0, 1'b0, 1'b1, a[3:0]);
			ctl(1'b0, 1'b1, 1'b0, 1'b1, a[3:0]);
			ctl(1'b0, 1'b1, 1'b0, 1'b1, ~a[3:0]);
			repeat (2) @(posedge i_clock);
			chk("chan_sel", 32'(16'h1 << a), {16'h0, chan});
			rchk(OFF_STATUS[7:0], 32'(a), RESP_OKAY);
		end
		ctl(1'b0, 1'b0, 1'b0, 1'b0, 4'h3);
		repeat (2) @(posedge i_clock);
		chk("chan_off", 32'h0, {16'h0, chan});
		wr(OFF_IRQ_MSK[7:0], 32'h1);
		conv(8'h00, 1'b0);
		conv(8'hff, 1'b1);
		chk("irq_set", 32'h1, {31'h0, irq});
		wr(OFF_IRQ_ST[7:0], 32'h1);
		repeat (2) @(posedge i_clock);
		chk("irq_clr", 32'h0, {31'h0, irq});
		for (int k = 0; k < 8; k++) begin
			conv(8'($urandom), 1'($urandom));
		end
		wr(OFF_IRQ_MSK[7:0], 32'h0);
		repeat (2) @(posedge i_clock);
		chk("irq_mask", 32'h0, {31'h0, irq});
		rchk(OFF_IRQ_ST[7:0], 32'h1, RESP_OKAY);
		ctl(1'b0, 1'b0, 1'b0, 1'b1, 4'h0);
		repeat (2) @(posedge i_clock);
		chk("result_off", 32'h0, {24'h0, res_oe});
		rchk(8'h20, 32'h0, RESP_SLVERR);
		close_out;
	end
endmodule
`default_nettype wire
